// ===== rtl/sau_ctl_pkg.sv
// Operation
// - enable status register is read only, channel bits low, upper bits zero
// - writing 1 to a stop trigger bit clears enable status and halts channel
// - stop trigger bits self clear once enable status is 0, never stored
// - stopped channel: software clock output level bit drives the clock pin
// - output enable 0 releases data output; data level bit becomes software writable
// - enable status set only by start trigger, cleared only by stop trigger or reset
// - operating channel with output enabled: levels follow the transfer
package sau_ctl_pkg;
    localparam int          NUM_CH        = 4;
    localparam logic [11:0] OFS_START     = 12'h000;
    localparam logic [11:0] OFS_STOP      = 12'h004;
    localparam logic [11:0] OFS_STATUS    = 12'h008;
    localparam logic [11:0] OFS_OE        = 12'h00c;
    localparam logic [11:0] OFS_OUT_LVL   = 12'h010;
    localparam logic [11:0] OFS_MODE      = 12'h014;
    localparam logic [11:0] OFS_CLK_EN    = 12'h018;
    localparam logic [11:0] OFS_PRESCALE  = 12'h01c;
    // output level register: data levels [3:0], clock levels [11:8]
    localparam int          LVL_DATA_POS  = 0;
    localparam int          LVL_CLK_POS   = 8;
    // mode register per channel byte: [1:0] mode, [2] txe, [3] rxe
    localparam int          MODE_TXE_POS  = 2;
    localparam int          MODE_RXE_POS  = 3;
    localparam logic [1:0]  MODE_CSI      = 2'h0;
    localparam logic [1:0]  MODE_UART     = 2'h1;
    localparam logic [1:0]  MODE_I2C      = 2'h2;
    localparam logic [3:0]  RST_LVL       = 4'hf;
    localparam logic [31:0] RST_MODE      = 32'h0101_0101;
    localparam logic [3:0]  RST_OE        = 4'h0;
    localparam int          CLK_WAIT_CYC  = 4;
    localparam int          CLK_MHZ       = 25;
    localparam int          BIT_TIME_NS   = 1000;
    localparam int          BIT_CYC       = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage : sau_ctl_pkg

// ===== rtl/sau_shift_ch.sv
`timescale 1ns/100ps
// per channel transfer engine: shifts i_tx_byte out lsb first, over and over, while enabled
module sau_shift_ch #(
    parameter int BIT_CYC = sau_ctl_pkg::BIT_CYC
) (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    // control
    input  wire logic       i_run,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_txe,
    input  wire logic [7:0] i_tx_byte,
    // line levels
    output logic            o_data,
    output logic            o_clk
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0]  bit_idx;
        logic        phase;
        logic        data;
        logic        clk;
    } st_t;
    st_t st_r;
    st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!i_run) begin
            st_nxt = '{cnt: 16'h0000, bit_idx: 3'h0, phase: 1'b0, data: 1'b1, clk: 1'b1};
        end else if (st_r.cnt == 16'(BIT_CYC - 1)) begin
            st_nxt.cnt   = 16'h0000;
            st_nxt.phase = ~st_r.phase;
            // uart has no clock; keep it idle high
            st_nxt.clk   = (i_mode == sau_ctl_pkg::MODE_UART) ? 1'b1 : st_r.phase;
            if (!st_r.phase) begin
                st_nxt.data    = i_txe ? i_tx_byte[st_r.bit_idx] : 1'b1;
                st_nxt.bit_idx = st_r.bit_idx + 3'h1;
            end
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_r <= '{cnt: 16'h0000, bit_idx: 3'h0, phase: 1'b0, data: 1'b1, clk: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_data = st_r.data;
    assign o_clk  = st_r.clk;
endmodule : sau_shift_ch

// ===== rtl/sau_apb_regs.sv
`timescale 1ns/100ps
// apb slave decode: zero wait state, error on unmapped address
module sau_apb_regs (
    // apb
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    output logic             o_pready,
    output logic             o_pslverr,
    // decode
    output logic             o_wr,
    output logic             o_rd,
    output logic [7:0]       o_hit
);
    function automatic logic [7:0] dec(input logic [11:0] a);
        dec = 8'h00;
        if (a[11:5] == 7'h00 && a[1:0] == 2'h0) begin
            dec[a[4:2]] = 1'b1;
        end
    endfunction : dec

    always_comb begin
        o_hit     = dec(i_paddr);
        o_pready  = 1'b1;
        o_pslverr = i_psel && i_penable && (o_hit == 8'h00);
        o_wr      = i_psel && i_penable && i_pwrite && (o_hit != 8'h00);
        o_rd      = i_psel && !i_pwrite;
    end
endmodule : sau_apb_regs

// ===== rtl/sau_stop_ctrl.sv
`timescale 1ns/100ps
module sau_stop_ctrl #(
    parameter int NUM_CH = sau_ctl_pkg::NUM_CH
) (
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [11:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // serial lines
    output logic [NUM_CH-1:0]      o_data_out,
    output logic [NUM_CH-1:0]      o_clk_out,
    output logic [NUM_CH-1:0]      o_pin_serial
);
    typedef struct packed {
        logic [3:0]  enable;
        logic [3:0]  oe;
        logic [3:0]  data_lvl;
        logic [3:0]  clk_lvl;
        logic [31:0] mode;
        logic        clk_en;
        logic [2:0]  clk_wait;
        logic [7:0]  prescale;
        logic [31:0] rdata;
    } st_t;
    st_t st_r;
    st_t st_nxt;

    logic       wr;
    logic       rd;
    logic [7:0] hit;
    logic [3:0] eng_data;
    logic [3:0] eng_clk;

    sau_apb_regs u_apb (
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr),
        .o_wr      (wr),
        .o_rd      (rd),
        .o_hit     (hit)
    );

    for (genvar g = 0; g < 4; g++) begin : g_ch
        sau_shift_ch u_ch (
            .i_core_clk (i_core_clk),
            .i_rst_n    (i_rst_n),
            .i_run      (st_r.enable[g]),
            .i_mode     (st_r.mode[8*g +: 2]),
            .i_txe      (st_r.mode[8*g + sau_ctl_pkg::MODE_TXE_POS]),
            .i_tx_byte  (st_r.prescale),
            .o_data     (eng_data[g]),
            .o_clk      (eng_clk[g])
        );
        // data: engine drives when operating with output enabled; clock: engine drives whenever operating; else software levels
        assign o_data_out[g]   = (st_r.enable[g] && st_r.oe[g]) ? eng_data[g] : st_r.data_lvl[g];
        assign o_clk_out[g]    = st_r.enable[g] ? eng_clk[g] : st_r.clk_lvl[g];
        // stopped channel gives its pins back to port functions
        assign o_pin_serial[g] = st_r.enable[g];
    end

    always_comb begin
        st_nxt = st_r;
        if (st_r.clk_wait != 3'h0) begin
            st_nxt.clk_wait = st_r.clk_wait - 3'h1;
        end
        if (wr) begin
            if (hit[sau_ctl_pkg::OFS_START[4:2]]) begin
                st_nxt.enable = st_r.enable | i_pwdata[3:0];
            end
            if (hit[sau_ctl_pkg::OFS_STOP[4:2]]) begin
                // trigger acts only this cycle, nothing stored
                st_nxt.enable = st_r.enable & ~i_pwdata[3:0];
            end
            if (hit[sau_ctl_pkg::OFS_OE[4:2]]) begin
                st_nxt.oe = i_pwdata[3:0];
            end
            if (hit[sau_ctl_pkg::OFS_OUT_LVL[4:2]]) begin
                for (int i = 0; i < 4; i++) begin
                    // level bits take software writes only when not driven by hardware
                    if (!(st_r.enable[i] && st_r.oe[i])) begin
                        st_nxt.data_lvl[i] = i_pwdata[sau_ctl_pkg::LVL_DATA_POS + i];
                    end
                    if (!st_r.enable[i]) begin
                        st_nxt.clk_lvl[i] = i_pwdata[sau_ctl_pkg::LVL_CLK_POS + i];
                    end
                end
            end
            if (hit[sau_ctl_pkg::OFS_MODE[4:2]]) begin
                st_nxt.mode = i_pwdata;
            end
            if (hit[sau_ctl_pkg::OFS_CLK_EN[4:2]]) begin
                st_nxt.clk_en = i_pwdata[0];
                if (i_pwdata[0] && !st_r.clk_en) begin
                    st_nxt.clk_wait = 3'(sau_ctl_pkg::CLK_WAIT_CYC);
                end
            end
            // software owns the wait; a write during it is still accepted
            if (hit[sau_ctl_pkg::OFS_PRESCALE[4:2]] && st_r.clk_en) begin
                st_nxt.prescale = i_pwdata[7:0];
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (st_nxt.enable[i] && st_nxt.oe[i]) begin
                st_nxt.data_lvl[i] = eng_data[i];
            end
            if (st_nxt.enable[i]) begin
                st_nxt.clk_lvl[i] = eng_clk[i];
            end
        end
        st_nxt.rdata = 32'h0000_0000;
        if (rd) begin
            case (i_paddr)
                sau_ctl_pkg::OFS_STATUS:   st_nxt.rdata = {28'h000_0000, st_r.enable};
                sau_ctl_pkg::OFS_OE:       st_nxt.rdata = {28'h000_0000, st_r.oe};
                sau_ctl_pkg::OFS_OUT_LVL:  st_nxt.rdata = {20'h0_0000, st_r.clk_lvl, 4'h0, st_r.data_lvl};
                sau_ctl_pkg::OFS_MODE:     st_nxt.rdata = st_r.mode;
                sau_ctl_pkg::OFS_CLK_EN:   st_nxt.rdata = {31'h0000_0000, st_r.clk_en};
                sau_ctl_pkg::OFS_PRESCALE: st_nxt.rdata = {24'h00_0000, st_r.prescale};
                default:                   st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_r.enable   <= 4'h0;
            st_r.oe       <= sau_ctl_pkg::RST_OE;
            st_r.data_lvl <= sau_ctl_pkg::RST_LVL;
            st_r.clk_lvl  <= sau_ctl_pkg::RST_LVL;
            st_r.mode     <= sau_ctl_pkg::RST_MODE;
            st_r.clk_en   <= 1'b0;
            st_r.clk_wait <= 3'h0;
            st_r.prescale <= 8'h00;
            st_r.rdata    <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // read data registered in setup, valid in access phase
    assign o_prdata = st_r.rdata;
endmodule : sau_stop_ctrl

// ===== sim/sau_line_peer.sv
`timescale 1ns/100ps
// far-side listener on channel 0: counts line events, never drives
module sau_line_peer (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    // lines
    input  wire logic       i_data,
    input  wire logic       i_sclk,
    // events seen
    output logic [7:0]      o_start_cnt,
    output logic [7:0]      o_stop_cnt,
    output logic [7:0]      o_edge_cnt
);
    logic d_q;
    logic c_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            {d_q, c_q, o_start_cnt, o_stop_cnt, o_edge_cnt} <= {2'b11, 24'h0};
        end else begin
            d_q <= i_data;
            c_q <= i_sclk;
            if (c_q && i_sclk && d_q && !i_data) o_start_cnt <= o_start_cnt + 8'h01;
            if (c_q && i_sclk && !d_q && i_data) o_stop_cnt <= o_stop_cnt + 8'h01;
            if (d_q != i_data) o_edge_cnt <= o_edge_cnt + 8'h01;
        end
    end
endmodule : sau_line_peer

// ===== sim/sau_stop_ctrl_properties.sv
`timescale 1ns/100ps
module sau_stop_ctrl_properties #(
    parameter int NUM_CH = 4
) (
    // clock, reset, apb
    input wire logic              i_core_clk,
    input wire logic              i_rst_n,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [11:0]       i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic [31:0]       o_prdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    // lines
    input wire logic [NUM_CH-1:0] o_data_out,
    input wire logic [NUM_CH-1:0] o_clk_out,
    input wire logic [NUM_CH-1:0] o_pin_serial
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic              acc;
    logic              wr;
    logic [NUM_CH-1:0] oe_r;
    assign acc = i_psel && i_penable;
    assign wr  = acc && i_pwrite;
    // shadow of output enables: tells who owns each data line
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) oe_r <= '0;
        else if (wr && i_paddr == sau_ctl_pkg::OFS_OE) oe_r <= i_pwdata[NUM_CH-1:0];
    end
    sequence s_wr(logic [11:0] a); wr && i_paddr == a; endsequence
    sequence s_rd(logic [11:0] a); acc && !i_pwrite && i_paddr == a; endsequence
    ////////////////////////////////////////////////////////////////////////
    a_status_upper: assert property (s_rd(sau_ctl_pkg::OFS_STATUS) |-> o_prdata[31:NUM_CH] == '0)
        else $error("status upper bits not zero");
    a_stop_clears: assert property (s_wr(sau_ctl_pkg::OFS_STOP) |=> (o_pin_serial & $past(i_pwdata[NUM_CH-1:0])) == '0)
        else $error("stopped channel still enabled");
    a_stop_reads_zero: assert property (s_rd(sau_ctl_pkg::OFS_STOP) |-> o_prdata == '0)
        else $error("stop trigger holds a value");
    a_clk_sw_level: assert property (s_wr(sau_ctl_pkg::OFS_OUT_LVL) |=> ((o_clk_out ^ $past(i_pwdata[8+:NUM_CH])) & ~$past(o_pin_serial)) == '0)
        else $error("clock level write lost on stopped channel");
    a_data_sw_level: assert property (s_wr(sau_ctl_pkg::OFS_OUT_LVL) |=> ((o_data_out ^ $past(i_pwdata[NUM_CH-1:0])) & ~$past(oe_r)) == '0)
        else $error("data level write lost with output disabled");
    a_start_only: assert property ((o_pin_serial & ~$past(o_pin_serial)) != '0 |-> $past(wr && i_paddr == sau_ctl_pkg::OFS_START))
        else $error("channel enabled without start trigger");
    a_reset_levels: assert property ($rose(i_rst_n) |-> o_data_out == '1 && o_clk_out == '1 && o_pin_serial == '0)
        else $error("stopped levels not high after reset");
    a_unmapped_err: assert property (acc && i_paddr > sau_ctl_pkg::OFS_PRESCALE |-> o_pslverr)
        else $error("unmapped access not flagged");
endmodule : sau_stop_ctrl_properties
bind sau_stop_ctrl sau_stop_ctrl_properties #(.NUM_CH(NUM_CH)) u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_data_out(o_data_out),
    .o_clk_out(o_clk_out), .o_pin_serial(o_pin_serial));

// ===== sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic        pready;
    logic        pslverr;
    logic        ev;
    logic [3:0]  dout;
    logic [3:0]  cout;
    logic [3:0]  pin;
    logic [7:0]  n_start;
    logic [7:0]  n_stop;
    logic [7:0]  n_edge;
    logic [7:0]  e0;
    int          error_cnt = 0;
    int          num_checks = 0;
    always #20 clk = ~clk;
    sau_stop_ctrl #(.NUM_CH(4)) dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_data_out(dout), .o_clk_out(cout), .o_pin_serial(pin));
    sau_line_peer peer (.i_core_clk(clk), .i_rst_n(rst_n), .i_data(dout[0]), .i_sclk(cout[0]),
        .o_start_cnt(n_start), .o_stop_cnt(n_stop), .o_edge_cnt(n_edge));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, then one idle cycle
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // answer and read data are taken at the rising edge that sees pready high
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rv, exp);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(sau_ctl_pkg::OFS_STATUS, 32'h0);
        rd(sau_ctl_pkg::OFS_OUT_LVL, 32'h0f0f);
        rd(sau_ctl_pkg::OFS_MODE, sau_ctl_pkg::RST_MODE);
        rd(sau_ctl_pkg::OFS_STOP, 32'h0);
        chk({20'h0, pin, cout, dout}, 32'h0ff);
        apb(12'h020, 1'b0, 32'h0);
        chk({31'h0, ev}, 32'h1);
        // software i2c framing on a stopped channel with output disabled
        apb(sau_ctl_pkg::OFS_OUT_LVL, 1'b1, 32'h0f0e);
        chk({20'h0, pin, cout, dout}, 32'h0fe);
        apb(sau_ctl_pkg::OFS_OUT_LVL, 1'b1, 32'h0e0e);
        chk({20'h0, pin, cout, dout}, 32'h0ee);
        apb(sau_ctl_pkg::OFS_OUT_LVL, 1'b1, 32'h0f0e);
        apb(sau_ctl_pkg::OFS_OUT_LVL, 1'b1, 32'h0f0f);
        // peer counts one edge after the level changes
        @(posedge clk);
        chk({16'h0, n_start, n_stop}, 32'h0101);
        // prescale write refused while the clock supply is off
        apb(sau_ctl_pkg::OFS_PRESCALE, 1'b1, 32'h33);
        rd(sau_ctl_pkg::OFS_PRESCALE, 32'h0);
        // clock supply, then prescale after the settling wait
        apb(sau_ctl_pkg::OFS_CLK_EN, 1'b1, 32'h1);
        repeat (sau_ctl_pkg::CLK_WAIT_CYC) @(posedge clk);
        rd(sau_ctl_pkg::OFS_CLK_EN, 32'h1);
        apb(sau_ctl_pkg::OFS_PRESCALE, 1'b1, 32'h5a);
        rd(sau_ctl_pkg::OFS_PRESCALE, 32'h5a);
        // ch0 csi tx, ch1 i2c tx, ch2 uart tx paired with ch3 uart rx
        apb(sau_ctl_pkg::OFS_MODE, 1'b1, 32'h0905_0604);
        rd(sau_ctl_pkg::OFS_MODE, 32'h0905_0604);
        apb(sau_ctl_pkg::OFS_OE, 1'b1, 32'hf);
        rd(sau_ctl_pkg::OFS_OE, 32'hf);
        e0 = n_edge;
        apb(sau_ctl_pkg::OFS_START, 1'b1, 32'hf);
        rd(sau_ctl_pkg::OFS_STATUS, 32'hf);
        repeat (400) @(posedge clk);
        chk({31'h0, n_edge != e0}, 32'h1);
        apb(sau_ctl_pkg::OFS_STOP, 1'b1, 32'ha);
        rd(sau_ctl_pkg::OFS_STATUS, 32'h5);
        rd(sau_ctl_pkg::OFS_STOP, 32'h0);
        apb(sau_ctl_pkg::OFS_STATUS, 1'b1, 32'h0);
        rd(sau_ctl_pkg::OFS_STATUS, 32'h5);
        apb(sau_ctl_pkg::OFS_OE, 1'b1, 32'h0);
        apb(sau_ctl_pkg::OFS_STOP, 1'b1, 32'h5);
        apb(sau_ctl_pkg::OFS_OUT_LVL, 1'b1, 32'h0a05);
        chk({20'h0, pin, cout, dout}, 32'h0a5);
        wrap_up();
    end
endmodule : tb_top
